// ### pkg/agta_regs_regs.vh
// Constants for the address generation and table access block.
// Assumes byte addressing on a 32-bit AHB-Lite register bus.
`ifndef AGTA_REGS_REGS_VH
`define AGTA_REGS_REGS_VH

// Register byte offsets
`define AGTA_OFS_MODCTL 8'h00
`define AGTA_OFS_MODSTART 8'h04
`define AGTA_OFS_MODEND 8'h08
`define AGTA_OFS_BREVCTL 8'h0C
`define AGTA_OFS_TBLPAGE 8'h10
`define AGTA_OFS_STATUS 8'h14
`define AGTA_OFS_GEOMETRY 8'h18

// Modulo control fields
`define AGTA_MOD_EN_BIT 15
`define AGTA_BWM_HI 11
`define AGTA_BWM_LO 8
`define AGTA_MODW_HI 3
`define AGTA_MODW_LO 0

// Bit-reverse control fields
`define AGTA_BITREV_ENABLE_BIT_BIT 15
`define AGTA_XB_HI 14

// Reset values
`define AGTA_MODCTL_RST 16'h0F0F
`define AGTA_MODSTART_RST 16'h0000
`define AGTA_MODEND_RST 16'hFFFF
`define AGTA_BREVCTL_RST 16'h0000
`define AGTA_TBLPAGE_RST 8'h00

// Stack pointer select, never usable for bit-reversal
`define AGTA_SP_SEL 4'hF

// Addressing modes from the execution logic
`define AGTA_AM_IND 3'h0
`define AGTA_AM_POSTDEC 3'h1
`define AGTA_AM_POSTINC 3'h2
`define AGTA_AM_PREDEC 3'h3
`define AGTA_AM_PREINC 3'h4
`define AGTA_AM_OFFS 3'h5

// Table operations
`define AGTA_TOP_RDL 2'h0
`define AGTA_TOP_RDH 2'h1
`define AGTA_TOP_WRL 2'h2
`define AGTA_TOP_WRH 2'h3

// Program counter step per 24-bit word
`define AGTA_PC_STEP 24'h000002

// Self-programming geometry in instructions
`define AGTA_ROW_INSTR 16'h0040
`define AGTA_PAGE_INSTR 16'h0200

`endif

// ### logic/agta_brev.v
// Bit-reversed carry adder for the X write address path.
// Assumes a word-aligned pointer; the result always has bit 0 clear.
`timescale 1ns/100ps

module agta_brev (
   ptr,
   xb,
   brev_sum
);
   input wire [15:0] ptr; // Pointer register value
   input wire [14:0] xb; // Word-sized pivot point
   output wire [15:0] brev_sum; // Bit-reversed sum

   // Mirror a 16-bit word
   function [15:0] rev16;
      input [15:0] v;
      integer i;
      begin
         for (i = 0; i < 16; i = i + 1) begin
            rev16[i] = v[15 - i];
         end
      end
   endfunction

   wire [15:0] ptr_al; // Pointer with LSb dropped
   wire [15:0] xb_byte; // Pivot scaled to bytes
   wire [15:0] rsum; // Sum in mirrored order

   assign ptr_al = {ptr[15:1], 1'b0};
   assign xb_byte = {xb, 1'b0};
   // Carry runs from MSb downward, so add in mirrored order
   assign rsum = rev16(ptr_al) + rev16(xb_byte);
   assign brev_sum = rev16(rsum) & 16'hFFFE;

endmodule // agta_brev

// ### logic/agta_top.v
// Data address generator with modulo and bit-reversed modes, plus
// the table access path from 16-bit data onto 24-bit program words.
// Assumes one clock, an AHB-Lite master for the control registers,
// an execution unit that pulses requests, and a program memory that
// returns read data one cycle after its read strobe.
`timescale 1ns/100ps
`include "agta_regs_regs.vh"

////////////////////////////////////////////////////////////////////////
module agta_top (
   hclk,
   hresetn,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hrdata,
   hreadyout,
   hresp,
   agen_req,
   agen_ptr_sel,
   agen_ptr,
   agen_mode,
   agen_offset,
   agen_write,
   agen_byte,
   agen_valid,
   agen_ea,
   agen_wb_en,
   agen_wb_val,
   agen_brev_used,
   pc_advance,
   pc_value,
   tbl_req,
   tbl_op,
   tbl_ea,
   tbl_byte,
   tbl_wdata,
   tbl_busy,
   tbl_done,
   tbl_rdata,
   pm_addr,
   pm_cfg_space,
   pm_rd,
   pm_wr,
   pm_wstrb,
   pm_wdata,
   pm_rdata
);
   input wire hclk;
   input wire hresetn;
   input wire hsel;
   input wire [31:0] haddr;
   input wire [1:0] htrans;
   input wire hwrite;
   input wire [2:0] hsize;
   input wire [31:0] hwdata;
   input wire hready;
   output reg [31:0] hrdata;
   output reg hreadyout;
   output reg hresp;
   input wire agen_req;
   input wire [3:0] agen_ptr_sel;
   input wire [15:0] agen_ptr;
   input wire [2:0] agen_mode;
   input wire [15:0] agen_offset;
   input wire agen_write;
   input wire agen_byte;
   output reg agen_valid;
   output reg [15:0] agen_ea;
   output reg agen_wb_en;
   output reg [15:0] agen_wb_val;
   output reg agen_brev_used;
   input wire pc_advance;
   output reg [23:0] pc_value;
   input wire tbl_req;
   input wire [1:0] tbl_op;
   input wire [15:0] tbl_ea;
   input wire tbl_byte;
   input wire [15:0] tbl_wdata;
   output reg tbl_busy;
   output reg tbl_done;
   output reg [15:0] tbl_rdata;
   output reg [23:0] pm_addr;
   output reg pm_cfg_space;
   output reg pm_rd;
   output reg pm_wr;
   output reg [2:0] pm_wstrb;
   output reg [23:0] pm_wdata;
   input wire [23:0] pm_rdata;

   // Table access states
   localparam TS_IDLE = 2'd0;
   localparam TS_STROBE = 2'd1;
   localparam TS_CAPTURE = 2'd2;

   ////////////////////////////////////////////////////////////////////
   // Registers
   reg [15:0] modctl_r; // Modulo enable and pointer selects
   reg [15:0] modstart_r; // Modulo buffer lower bound
   reg [15:0] modend_r; // Modulo buffer upper bound
   reg [15:0] brevctl_r; // Bit-reverse enable and pivot
   reg [7:0] tblpage_r; // Upper program address byte
   reg mod_wrap_r; // Last request was wrapped
   reg [1:0] tstate_r; // Table access state
   reg [1:0] top_r; // Latched table op
   reg tbsel_r; // Latched byte select
   reg tbyte_r; // Latched byte mode
   reg dph_wr_r; // Pending write data phase
   reg [7:0] dph_addr_r; // Its register offset

   ////////////////////////////////////////////////////////////////////
   // Functions

   // Modulo correction for either direction
   function [15:0] mod_fix;
      input [15:0] a;
      input up;
      input [15:0] lo;
      input [15:0] hi;
      reg [15:0] len;
      begin
         len = hi - lo + 16'h0001;
         if (up && (a > hi)) begin
            mod_fix = a - len;
         end else if (!up && (a < lo)) begin
            mod_fix = a + len;
         end else begin
            mod_fix = a;
         end
      end
   endfunction

   // Map a 24-bit program word onto a 16-bit data word
   function [15:0] tbl_map;
      input high;
      input byte_mode;
      input bsel;
      input [23:0] p;
      begin
         if (!high && !byte_mode) begin
            tbl_map = p[15:0];
         end else if (!high) begin
            tbl_map = {8'h00, (bsel ? p[15:8] : p[7:0])};
         end else if (!byte_mode) begin
            tbl_map = {8'h00, p[23:16]};
         end else begin
            tbl_map = {8'h00, (bsel ? 8'h00 : p[23:16])};
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Address generation, combinational part
   wire mod_en = modctl_r[`AGTA_MOD_EN_BIT];
   wire [3:0] mod_wsel = modctl_r[`AGTA_MODW_HI:`AGTA_MODW_LO];
   wire [3:0] bwm_sel = modctl_r[`AGTA_BWM_HI:`AGTA_BWM_LO];
   wire bitrev_enable_bit = brevctl_r[`AGTA_BITREV_ENABLE_BIT_BIT];
   wire [14:0] xb_val = brevctl_r[`AGTA_XB_HI:0];
   wire [15:0] brev_sum; // Pointer plus reversed pivot

   agta_brev u_brev (
      .ptr(agen_ptr),
      .xb(xb_val),
      .brev_sum(brev_sum)
   );

   reg [15:0] step; // Increment size in bytes
   reg [15:0] raw_sum; // Unwrapped new address
   reg up_dir; // Buffer grows upward
   reg modifies; // Pre or post modify mode
   reg is_pre; // Address used after modify
   reg inc_mode; // Pre or post increment
   reg brev_arm; // Bit-reversal applies
   reg mod_apply; // Modulo applies
   reg [15:0] fixed; // After modulo correction
   reg [15:0] ea_nxt; // Effective address
   reg [15:0] wb_nxt; // Pointer write-back value

   // Mode decode and address arithmetic
   always @* begin
      step = agen_byte ? 16'h0001 : 16'h0002;
      modifies = 1'b1;
      is_pre = 1'b0;
      inc_mode = 1'b0;
      up_dir = 1'b1;
      case (agen_mode)
         `AGTA_AM_POSTDEC: begin
            raw_sum = agen_ptr - step;
            up_dir = 1'b0;
         end
         `AGTA_AM_POSTINC: begin
            raw_sum = agen_ptr + step;
            inc_mode = 1'b1;
         end
         `AGTA_AM_PREDEC: begin
            raw_sum = agen_ptr - step;
            up_dir = 1'b0;
            is_pre = 1'b1;
         end
         `AGTA_AM_PREINC: begin
            raw_sum = agen_ptr + step;
            inc_mode = 1'b1;
            is_pre = 1'b1;
         end
         `AGTA_AM_OFFS: begin
            raw_sum = agen_ptr + agen_offset;
            up_dir = ~agen_offset[15];
            modifies = 1'b0;
            is_pre = 1'b1;
         end
         default: begin
            raw_sum = agen_ptr;
            modifies = 1'b0;
         end
      endcase
      // Only write accesses of the X write unit
      brev_arm = bitrev_enable_bit && (bwm_sel != `AGTA_SP_SEL) &&
         (agen_ptr_sel == bwm_sel) && inc_mode && agen_write && !agen_byte;
      // Any working register may be selected
      mod_apply = mod_en && (agen_ptr_sel == mod_wsel) &&
         (agen_mode != `AGTA_AM_IND) && !brev_arm;
      // Compare past the bound, not only equal
      fixed = mod_apply ? mod_fix(raw_sum, up_dir, modstart_r, modend_r) : raw_sum;
      if (brev_arm) begin
         // Pivot replaces step, LSb forced clear
         ea_nxt = is_pre ? brev_sum : {agen_ptr[15:1], 1'b0};
         wb_nxt = brev_sum;
      end else begin
         ea_nxt = is_pre ? fixed : agen_ptr;
         wb_nxt = fixed;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address generation outputs, one cycle after the request
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         agen_valid <= 1'b0;
         agen_ea <= 16'h0000;
         agen_wb_en <= 1'b0;
         agen_wb_val <= 16'h0000;
         agen_brev_used <= 1'b0;
         mod_wrap_r <= 1'b0;
      end else begin
         agen_valid <= agen_req;
         if (agen_req) begin
            agen_ea <= ea_nxt;
            // Offset mode leaves the pointer untouched
            agen_wb_en <= modifies;
            agen_wb_val <= wb_nxt;
            agen_brev_used <= brev_arm;
            mod_wrap_r <= mod_apply && (fixed != raw_sum);
         end else begin
            agen_wb_en <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Program counter
   // Two addresses per 24-bit word
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_value <= 24'h000000;
      end else if (pc_advance) begin
         pc_value <= pc_value + `AGTA_PC_STEP;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Table access sequencer
   wire t_high = tbl_op[0]; // High-side operation
   wire t_write = tbl_op[1]; // Write operation

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tstate_r <= TS_IDLE;
         top_r <= `AGTA_TOP_RDL;
         tbsel_r <= 1'b0;
         tbyte_r <= 1'b0;
         tbl_busy <= 1'b0;
         tbl_done <= 1'b0;
         tbl_rdata <= 16'h0000;
         pm_addr <= 24'h000000;
         pm_cfg_space <= 1'b0;
         pm_rd <= 1'b0;
         pm_wr <= 1'b0;
         pm_wstrb <= 3'b000;
         pm_wdata <= 24'h000000;
      end else begin
         tbl_done <= 1'b0;
         pm_rd <= 1'b0;
         pm_wr <= 1'b0;
         case (tstate_r)
            TS_IDLE: begin
               if (tbl_req) begin
                  top_r <= tbl_op;
                  tbsel_r <= tbl_ea[0];
                  tbyte_r <= tbl_byte;
                  // Page supplies the upper address byte
                  pm_addr <= {tblpage_r, tbl_ea[15:1], 1'b0};
                  pm_cfg_space <= tblpage_r[7];
                  tbl_busy <= 1'b1;
                  tstate_r <= TS_STROBE;
                  // Low ops hit bits 15..0, high ops 23..16
                  if (!t_write) begin
                     pm_rd <= 1'b1;
                  end else if (!t_high) begin
                     pm_wr <= 1'b1;
                     pm_wdata <= tbl_byte ?
                        {8'h00, tbl_wdata[7:0], tbl_wdata[7:0]} : {8'h00, tbl_wdata};
                     pm_wstrb <= !tbl_byte ? 3'b011 : (tbl_ea[0] ? 3'b010 : 3'b001);
                  end else begin
                     pm_wr <= 1'b1;
                     pm_wdata <= {tbl_wdata[7:0], 16'h0000};
                     // Phantom byte writes are dropped
                     pm_wstrb <= (tbl_byte && tbl_ea[0]) ? 3'b000 : 3'b100;
                  end
               end
            end
            TS_STROBE: begin
               // Writes end here, reads wait for memory data
               if (top_r[1]) begin
                  tbl_busy <= 1'b0;
                  tbl_done <= 1'b1;
                  pm_wstrb <= 3'b000;
                  tstate_r <= TS_IDLE;
               end else begin
                  tstate_r <= TS_CAPTURE;
               end
            end
            TS_CAPTURE: begin
               tbl_rdata <= tbl_map(top_r[0], tbyte_r, tbsel_r, pm_rdata);
               tbl_done <= 1'b1;
               tbl_busy <= 1'b0;
               tstate_r <= TS_IDLE;
            end
            default: begin
               tstate_r <= TS_IDLE;
               tbl_busy <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   wire addr_ok = hsel && hready && htrans[1]; // Valid address phase
   reg [31:0] rd_mux; // Read data for the current address

   // Register read decode; unmapped offsets read zero
   always @* begin
      case (haddr[7:0])
         `AGTA_OFS_MODCTL: rd_mux = {16'h0000, modctl_r};
         `AGTA_OFS_MODSTART: rd_mux = {16'h0000, modstart_r};
         `AGTA_OFS_MODEND: rd_mux = {16'h0000, modend_r};
         `AGTA_OFS_BREVCTL: rd_mux = {16'h0000, brevctl_r};
         `AGTA_OFS_TBLPAGE: rd_mux = {24'h000000, tblpage_r};
         `AGTA_OFS_STATUS:
            rd_mux = {12'h000, tbl_busy, mod_wrap_r, agen_brev_used, agen_wb_en, agen_ea};
         `AGTA_OFS_GEOMETRY: rd_mux = {`AGTA_PAGE_INSTR, `AGTA_ROW_INSTR};
         default: rd_mux = 32'h00000000;
      endcase
      if (haddr[31:8] != 24'h000000) begin
         rd_mux = 32'h00000000;
      end
   end

   // Address phase capture and read data
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dph_wr_r <= 1'b0;
         dph_addr_r <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dph_wr_r <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
         dph_addr_r <= haddr[7:0];
         if (addr_ok && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Register writes in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         modctl_r <= `AGTA_MODCTL_RST;
         modstart_r <= `AGTA_MODSTART_RST;
         modend_r <= `AGTA_MODEND_RST;
         brevctl_r <= `AGTA_BREVCTL_RST;
         tblpage_r <= `AGTA_TBLPAGE_RST;
      end else if (dph_wr_r) begin
         case (dph_addr_r)
            `AGTA_OFS_MODCTL: modctl_r <= hwdata[15:0];
            `AGTA_OFS_MODSTART: modstart_r <= hwdata[15:0];
            `AGTA_OFS_MODEND: modend_r <= hwdata[15:0];
            // Pivot held as 15-bit word count
            `AGTA_OFS_BREVCTL: brevctl_r <= hwdata[15:0];
            `AGTA_OFS_TBLPAGE: tblpage_r <= hwdata[7:0];
            default: modctl_r <= modctl_r;
         endcase
      end
   end

endmodule // agta_top

// ### testbench/agta_props.sv
// Port checker for agta_top: answer timing, write-back, bit-reversal.
// Assumes one clock hclk and the active-low reset hresetn.
`timescale 1ns/100ps
module agta_props (
   input wire hclk,
   input wire hresetn,
   input wire hreadyout,
   input wire hresp,
   input wire agen_req,
   input wire [3:0] agen_ptr_sel,
   input wire [2:0] agen_mode,
   input wire agen_write,
   input wire agen_byte,
   input wire agen_valid,
   input wire [15:0] agen_ea,
   input wire agen_wb_en,
   input wire [15:0] agen_wb_val,
   input wire agen_brev_used,
   input wire pc_advance,
   input wire [23:0] pc_value,
   input wire tbl_req,
   input wire [1:0] tbl_op,
   input wire tbl_busy,
   input wire tbl_done,
   input wire pm_rd,
   input wire pm_wr
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Slave never stalls nor errors
   property p_bus_okay;
      1'h1 |-> hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus stall or error");
   // Answer one cycle after request
   property p_agen_lat;
      agen_req |=> agen_valid;
   endproperty
   a_agen_lat: assert property (p_agen_lat) else $error("no address answer");
   property p_wb;
      agen_req |=> agen_wb_en == ($past(agen_mode) >= 3'h1 && $past(agen_mode) <= 3'h4);
   endproperty
   a_wb: assert property (p_wb) else $error("wrong write-back enable");
   property p_no_brev;
      agen_req && (agen_byte || !agen_write || agen_ptr_sel == 4'hF ||
         !(agen_mode == 3'h2 || agen_mode == 3'h4)) |=> !agen_brev_used;
   endproperty
   a_no_brev: assert property (p_no_brev) else $error("bit-reversal when not armed");
   property p_brev_lsb;
      agen_valid && agen_brev_used |-> !agen_ea[0] && !agen_wb_val[0];
   endproperty
   a_brev_lsb: assert property (p_brev_lsb) else $error("odd reversed address");
   property p_pc;
      pc_advance |=> pc_value == $past(pc_value) + 24'h2;
   endproperty
   a_pc: assert property (p_pc) else $error("bad program counter step");
   // read strobe then result two cycles on
   property p_tbl_rd;
      tbl_req && !tbl_busy && !tbl_op[1] |=> pm_rd ##2 tbl_done;
   endproperty
   a_tbl_rd: assert property (p_tbl_rd) else $error("table read sequence wrong");
   property p_tbl_wr;
      tbl_req && !tbl_busy && tbl_op[1] |=> pm_wr ##1 tbl_done;
   endproperty
   a_tbl_wr: assert property (p_tbl_wr) else $error("table write sequence wrong");
endmodule // agta_props

bind agta_top agta_props i_props (.hclk, .hresetn, .hreadyout, .hresp, .agen_req,
   .agen_ptr_sel, .agen_mode, .agen_write, .agen_byte, .agen_valid, .agen_ea,
   .agen_wb_en, .agen_wb_val, .agen_brev_used, .pc_advance, .pc_value, .tbl_req,
   .tbl_op, .tbl_busy, .tbl_done, .pm_rd, .pm_wr);

// ### testbench/agta_pmem.sv
// Program memory model for the table path: 16 words, read data one
// cycle after the strobe. Assumes word index from pm_addr[3:1].
`timescale 1ns/100ps
module agta_pmem (
   input wire hclk,
   input wire [23:0] pm_addr,
   input wire pm_cfg_space,
   input wire pm_rd,
   input wire pm_wr,
   input wire [2:0] pm_wstrb,
   input wire [23:0] pm_wdata,
   output logic [23:0] pm_rdata
);
   logic [23:0] mem [0:15]; // Half user, half configuration space
   wire [3:0] idx = {pm_cfg_space, pm_addr[3:1]};
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 24'h3C3C3C;
      pm_rdata = 24'h0;
   end
   // Lane writes; data outside the read slot keeps toggling so a late
   // sample never sees a stale but plausible value
   always @(posedge hclk) begin
      if (pm_wr && pm_wstrb[0]) mem[idx][7:0] <= pm_wdata[7:0];
      if (pm_wr && pm_wstrb[1]) mem[idx][15:8] <= pm_wdata[15:8];
      if (pm_wr && pm_wstrb[2]) mem[idx][23:16] <= pm_wdata[23:16];
      if (pm_rd) pm_rdata <= mem[idx];
      else pm_rdata <= ~pm_rdata;
   end
endmodule // agta_pmem

// ### testbench/agta_top_tb.sv
// Self-checking bench for agta_top: registers over AHB-Lite, modulo and
// bit-reversed addressing, table access, program counter.
// Assumes agta_pmem as program memory and agta_props bound to the top.
`timescale 1ns/100ps
`include "agta_regs_regs.vh"
module agta_top_tb;
   logic hclk, hresetn, hsel, hwrite, agen_req, agen_write, agen_byte;
   logic pc_advance, tbl_req, tbl_byte;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans, tbl_op;
   logic [2:0] hsize, agen_mode;
   logic [3:0] agen_ptr_sel;
   logic [15:0] agen_ptr, agen_offset, tbl_ea, tbl_wdata;
   wire [31:0] hrdata;
   wire hready, hresp, agen_valid, agen_wb_en, agen_brev_used;
   wire tbl_busy, tbl_done, pm_cfg_space, pm_rd, pm_wr;
   wire [15:0] agen_ea, agen_wb_val, tbl_rdata;
   wire [23:0] pc_value, pm_addr, pm_wdata, pm_rdata;
   wire [2:0] pm_wstrb;
   int failures = 0;
   int n_tests = 0;
   agta_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .agen_req(agen_req),
      .agen_ptr_sel(agen_ptr_sel), .agen_ptr(agen_ptr), .agen_mode(agen_mode),
      .agen_offset(agen_offset), .agen_write(agen_write), .agen_byte(agen_byte),
      .agen_valid(agen_valid), .agen_ea(agen_ea), .agen_wb_en(agen_wb_en),
      .agen_wb_val(agen_wb_val), .agen_brev_used(agen_brev_used),
      .pc_advance(pc_advance), .pc_value(pc_value), .tbl_req(tbl_req), .tbl_op(tbl_op),
      .tbl_ea(tbl_ea), .tbl_byte(tbl_byte), .tbl_wdata(tbl_wdata), .tbl_busy(tbl_busy),
      .tbl_done(tbl_done), .tbl_rdata(tbl_rdata), .pm_addr(pm_addr),
      .pm_cfg_space(pm_cfg_space), .pm_rd(pm_rd), .pm_wr(pm_wr), .pm_wstrb(pm_wstrb),
      .pm_wdata(pm_wdata), .pm_rdata(pm_rdata));
   agta_pmem i_pmem (.hclk(hclk), .pm_addr(pm_addr), .pm_cfg_space(pm_cfg_space),
      .pm_rd(pm_rd), .pm_wr(pm_wr), .pm_wstrb(pm_wstrb), .pm_wdata(pm_wdata),
      .pm_rdata(pm_rdata));
   initial begin
      hclk = 1'h0;
      forever #2.5 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input [31:0] got, input [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for hready sampled high at a rising edge
   task automatic rdy;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hready !== 1'h1 && i < 50);
      if (hready !== 1'h1) begin
         failures++;
         summarize();
      end
   endtask
   // One single transfer with hsize left at 0 (byte); read data taken at the data-phase edge
   task automatic bus(input [7:0] a, input w, input [31:0] d, input [31:0] e);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      if (!w) chk(hrdata, e);
   endtask
   // One address request; outputs judged in the answer cycle
   task automatic agen(input [3:0] s, input [15:0] p, input [2:0] m, input [15:0] o,
      input w, input b, input [15:0] ea, input [15:0] wb, input we, input bu);
      @(posedge hclk);
      agen_req <= 1'h1;
      agen_ptr_sel <= s;
      agen_ptr <= p;
      agen_mode <= m;
      agen_offset <= o;
      agen_write <= w;
      agen_byte <= b;
      @(posedge hclk);
      agen_req <= 1'h0;
      #1;
      chk({agen_valid, agen_brev_used, agen_wb_en, agen_ea}, {1'h1, bu, we, ea});
      if (we) chk(agen_wb_val, wb);
   endtask
   // One table operation; the memory address seen at the strobe is kept
   task automatic tbl(input [1:0] op, input [15:0] ea, input b, input [15:0] wd,
      input [23:0] pa, input [15:0] e);
      logic [23:0] seen;
      logic sc;
      seen = 24'h0;
      sc = 1'h0;
      @(posedge hclk);
      tbl_req <= 1'h1;
      tbl_op <= op;
      tbl_ea <= ea;
      tbl_byte <= b;
      tbl_wdata <= wd;
      @(posedge hclk);
      tbl_req <= 1'h0;
      for (int i = 0; i < 8 && tbl_done !== 1'h1; i++) begin
         #1;
         if (pm_rd === 1'h1 || pm_wr === 1'h1) {sc, seen} = {pm_cfg_space, pm_addr};
         if (tbl_done !== 1'h1) @(posedge hclk);
      end
      chk(tbl_done, 1'h1);
      chk({sc, seen}, {pa[23], pa});
      if (!op[1]) chk(tbl_rdata, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      bus(`AGTA_OFS_MODCTL, 1'h0, 32'h0, 32'h00000F0F);
      bus(`AGTA_OFS_MODEND, 1'h0, 32'h0, 32'h0000FFFF);
      bus(`AGTA_OFS_BREVCTL, 1'h0, 32'h0, 32'h0);
      bus(8'h80, 1'h1, 32'h1234, 32'h0);
      bus(8'h80, 1'h0, 32'h0, 32'h0);
      bus(`AGTA_OFS_GEOMETRY, 1'h0, 32'h0, 32'h02000040);
      $display("test regs done");
   endtask
   task automatic t_modulo;
      bus(`AGTA_OFS_MODSTART, 1'h1, 32'h1000, 32'h0);
      bus(`AGTA_OFS_MODEND, 1'h1, 32'h100F, 32'h0);
      bus(`AGTA_OFS_MODCTL, 1'h1, 32'h8F03, 32'h0);
      agen(4'h3, 16'h100E, 3'h2, 16'h0, 1'h1, 1'h0, 16'h100E, 16'h1000, 1'h1, 1'h0);
      agen(4'h3, 16'h1000, 3'h3, 16'h0, 1'h0, 1'h0, 16'h100E, 16'h100E, 1'h1, 1'h0);
      agen(4'h3, 16'h100C, 3'h5, 16'h6, 1'h0, 1'h0, 16'h1002, 16'h0, 1'h0, 1'h0);
      bus(`AGTA_OFS_STATUS, 1'h0, 32'h0, 32'h00041002);
      agen(4'h4, 16'h100E, 3'h2, 16'h0, 1'h0, 1'h0, 16'h100E, 16'h1010, 1'h1, 1'h0);
      $display("test modulo done");
   endtask
   task automatic t_brev;
      // enable written while idle, no read follows at once
      bus(`AGTA_OFS_BREVCTL, 1'h1, 32'h8008, 32'h0);
      agen(4'hF, 16'h0800, 3'h2, 16'h0, 1'h1, 1'h0, 16'h0800, 16'h0802, 1'h1, 1'h0);
      bus(`AGTA_OFS_MODSTART, 1'h1, 32'h0800, 32'h0);
      bus(`AGTA_OFS_MODEND, 1'h1, 32'h081F, 32'h0);
      bus(`AGTA_OFS_MODCTL, 1'h1, 32'h8202, 32'h0);
      // buffer of 32 bytes starts with five zero low bits
      agen(4'h2, 16'h0800, 3'h2, 16'h0, 1'h1, 1'h0, 16'h0800, 16'h0810, 1'h1, 1'h1);
      agen(4'h2, 16'h0810, 3'h2, 16'h0, 1'h1, 1'h0, 16'h0810, 16'h0808, 1'h1, 1'h1);
      agen(4'h2, 16'h0808, 3'h4, 16'h0, 1'h1, 1'h0, 16'h0818, 16'h0818, 1'h1, 1'h1);
      agen(4'h2, 16'h0818, 3'h2, 16'h0, 1'h1, 1'h1, 16'h0818, 16'h0819, 1'h1, 1'h0);
      agen(4'h2, 16'h081E, 3'h2, 16'h0, 1'h0, 1'h0, 16'h081E, 16'h0800, 1'h1, 1'h0);
      agen(4'h2, 16'h0800, 3'h1, 16'h0, 1'h1, 1'h0, 16'h0800, 16'h081E, 1'h1, 1'h0);
      agen(4'h2, 16'h0804, 3'h0, 16'h0, 1'h1, 1'h0, 16'h0804, 16'h0, 1'h0, 1'h0);
      $display("test bit-reverse done");
   endtask
   task automatic t_table;
      bus(`AGTA_OFS_TBLPAGE, 1'h1, 32'h80, 32'h0);
      tbl(`AGTA_TOP_WRL, 16'h4, 1'h0, 16'hBEEF, 24'h800004, 16'h0);
      tbl(`AGTA_TOP_WRH, 16'h4, 1'h0, 16'h00A5, 24'h800004, 16'h0);
      tbl(`AGTA_TOP_WRL, 16'h5, 1'h1, 16'h0012, 24'h800004, 16'h0);
      tbl(`AGTA_TOP_RDL, 16'h4, 1'h0, 16'h0, 24'h800004, 16'h12EF);
      tbl(`AGTA_TOP_RDL, 16'h5, 1'h1, 16'h0, 24'h800004, 16'h0012);
      tbl(`AGTA_TOP_RDL, 16'h4, 1'h1, 16'h0, 24'h800004, 16'h00EF);
      tbl(`AGTA_TOP_RDH, 16'h4, 1'h0, 16'h0, 24'h800004, 16'h00A5);
      tbl(`AGTA_TOP_RDH, 16'h4, 1'h1, 16'h0, 24'h800004, 16'h00A5);
      tbl(`AGTA_TOP_RDH, 16'h5, 1'h1, 16'h0, 24'h800004, 16'h0000);
      bus(`AGTA_OFS_TBLPAGE, 1'h1, 32'h0, 32'h0);
      tbl(`AGTA_TOP_RDL, 16'h4, 1'h0, 16'h0, 24'h000004, 16'h3C3C);
      $display("test table done");
   endtask
   task automatic t_pc;
      @(posedge hclk);
      pc_advance <= 1'h1;
      repeat (3) @(posedge hclk);
      pc_advance <= 1'h0;
      #1;
      chk(pc_value, 32'h6);
      $display("test counter done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {hresetn, hsel, hwrite, agen_req, agen_write, agen_byte} = 6'h0;
      {pc_advance, tbl_req, tbl_byte, tbl_op, hsize, agen_mode} = 11'h2;
      {haddr, hwdata, agen_ptr_sel, agen_ptr, agen_offset} = 100'h0;
      {htrans, tbl_ea, tbl_wdata} = 34'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'h1;
      t_regs();
      t_modulo();
      t_brev();
      t_table();
      t_pc();
      summarize();
   end
endmodule // agta_top_tb
